// File: adc_host_readout_interface.v
`timescale 1ns/100ps
`include "adc_if_defines.vh"
module adc_host_readout_interface #(
    parameter CONV_CYCLES = `CONV_CYCLES
) (
    // clock, reset, enable
    input  wire                CLK_IN,
    input  wire                RST_N_IN,
    input  wire                CE_IN,
    // mode straps
    input  wire                SOFTWARE_MODE_IN,
    input  wire                INTERFACE_SELECT_IN,
    input  wire                LINE_COUNT_SELECT_IN,
    input  wire [`PAIR_W-1:0]  PAIR_SELECT_PINS_IN,
    // conversion
    input  wire                SAMPLE_TRIGGER_IN,
    output wire                BUSY_OUT,
    output wire [`PAIR_W-1:0]  CONV_PAIR_OUT,
    input  wire [`RES_W-1:0]   BANK_A_RESULT_IN,
    input  wire [`RES_W-1:0]   BANK_B_RESULT_IN,
    // parallel bus
    input  wire                CS_N_IN,
    input  wire                RD_N_IN,
    input  wire                WR_N_IN,
    input  wire [`RES_W-1:0]   PARALLEL_DATA_LINES_IN,
    output wire [`RES_W-1:0]   PARALLEL_DATA_LINES_OUT,
    output wire                PARALLEL_DATA_LINES_OE_OUT,
    // serial bus
    input  wire                SCLK_IN,
    output wire                SERIAL_OUT_A_OUT,
    output wire                SERIAL_OUT_A_OE_OUT,
    output wire                SERIAL_OUT_B_OUT,
    output wire                SERIAL_OUT_B_OE_OUT,
    // register file port
    output wire                REG_WR_STROBE_OUT,
    output wire [`ADDR_W-1:0]  REG_ADDR_OUT,
    output wire [`WDATA_W-1:0] REG_WDATA_OUT,
    input  wire [`RES_W-1:0]   REG_RDATA_IN
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    wire [`PAIR_W-1:0] pair_s;
    wire [`RES_W-1:0]  pdata_s;
    wire               conv_s, cs_s, rd_s, wr_s, sclk_s, sw_s, ser_s, one_s;

    sync2 #(.W(`PAIR_W + 8)) u_sync_ctl (
        .clk   (CLK_IN),
        .rst_n (RST_N_IN),
        .ce    (CE_IN),
        .d     ({PAIR_SELECT_PINS_IN, SAMPLE_TRIGGER_IN, CS_N_IN, RD_N_IN, WR_N_IN,
                 SCLK_IN, SOFTWARE_MODE_IN, INTERFACE_SELECT_IN, LINE_COUNT_SELECT_IN}),
        .q     ({pair_s, conv_s, cs_s, rd_s, wr_s, sclk_s, sw_s, ser_s, one_s})
    );

    sync2 #(.W(`RES_W)) u_sync_data (
        .clk   (CLK_IN),
        .rst_n (RST_N_IN),
        .ce    (CE_IN),
        .d     (PARALLEL_DATA_LINES_IN),
        .q     (pdata_s)
    );

    // ****************************************
    // edge history and strap capture
    // ****************************************
    reg        conv_d_reg, cs_d_reg, rd_d_reg, wr_d_reg, sclk_d_reg;
    reg        strap_done_reg, sw_mode_reg, ser_mode_reg, two_wire_reg;
    reg [1:0]  strap_wait_reg; // synchroniser fill, straps valid once top bit set
    reg [`PAIR_W-1:0] pair_reg;
    reg [`PAIR_W-1:0] sw_pair_reg;

    wire conv_rise = conv_s && !conv_d_reg;
    wire cs_fall   = !cs_s && cs_d_reg;
    wire rd_fall   = !rd_s && rd_d_reg;
    wire wr_rise   = wr_s && !wr_d_reg;
    wire sclk_rise = sclk_s && !sclk_d_reg;

    // straps caught once, on the third edge after release
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            conv_d_reg     <= 1'b0;
            cs_d_reg       <= 1'b1;
            rd_d_reg       <= 1'b1;
            wr_d_reg       <= 1'b1;
            sclk_d_reg     <= 1'b0;
            strap_done_reg <= 1'b0;
            sw_mode_reg    <= 1'b0;
            ser_mode_reg   <= 1'b0;
            two_wire_reg   <= 1'b0;
            strap_wait_reg <= 2'h0;
        end else if (CE_IN) begin
            strap_wait_reg <= {strap_wait_reg[0], 1'b1};
            conv_d_reg <= conv_s;
            cs_d_reg   <= cs_s;
            rd_d_reg   <= rd_s;
            wr_d_reg   <= wr_s;
            sclk_d_reg <= sclk_s;
            if (!strap_done_reg && strap_wait_reg[1]) begin
                strap_done_reg <= 1'b1;
                sw_mode_reg    <= sw_s;
                ser_mode_reg   <= ser_s;
                two_wire_reg   <= one_s;
            end
        end
    end

    // ****************************************
    // conversion timing and pair selection
    // ****************************************
    reg                  busy_reg;
    reg [`CONV_CNT_W-1:0] conv_cnt_reg;
    reg                  done_pulse_reg;
    reg [`RES_W-1:0]     res_a_reg, res_b_reg;
    wire                 conv_start = !busy_reg && conv_rise && strap_done_reg;

    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            busy_reg       <= 1'b0;
            conv_cnt_reg   <= {`CONV_CNT_W{1'b0}};
            done_pulse_reg <= 1'b0;
            pair_reg       <= `PAIR_DEFAULT;
            res_a_reg      <= `ZERO_RESULT;
            res_b_reg      <= `ZERO_RESULT;
        end else if (CE_IN) begin
            done_pulse_reg <= 1'b0;
            if (!strap_done_reg)
                pair_reg <= sw_s ? sw_pair_reg : pair_s;
            else if (!sw_mode_reg && (busy_reg || conv_start))
                pair_reg <= pair_s;
            else if (sw_mode_reg)
                pair_reg <= sw_pair_reg;
            if (conv_start) begin
                busy_reg     <= 1'b1;
                conv_cnt_reg <= CONV_CYCLES[`CONV_CNT_W-1:0];
            end else if (busy_reg) begin
                if (conv_cnt_reg == {{(`CONV_CNT_W-1){1'b0}}, 1'b1}) begin
                    busy_reg       <= 1'b0;
                    done_pulse_reg <= 1'b1;
                    res_a_reg      <= BANK_A_RESULT_IN;
                    res_b_reg      <= BANK_B_RESULT_IN;
                end
                conv_cnt_reg <= conv_cnt_reg - 1'b1;
            end
        end
    end

    assign BUSY_OUT      = busy_reg;
    assign CONV_PAIR_OUT = pair_reg;

    // ****************************************
    // parallel commands
    // ****************************************
    reg               reg_wr_reg;
    reg [`ADDR_W-1:0]  reg_addr_reg;
    reg [`WDATA_W-1:0] reg_wdata_reg;
    reg               reg_out_pend_reg;
    reg [`RES_W-1:0]   reg_out_reg;
    wire              par_cmd = !ser_mode_reg && sw_mode_reg && wr_rise && !cs_s;

    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            reg_wr_reg       <= 1'b0;
            reg_addr_reg     <= {`ADDR_W{1'b0}};
            reg_wdata_reg    <= {`WDATA_W{1'b0}};
            reg_out_pend_reg <= 1'b0;
            reg_out_reg      <= `ZERO_RESULT;
            sw_pair_reg      <= `PAIR_DEFAULT;
        end else if (CE_IN) begin
            reg_wr_reg <= 1'b0;
            if (par_cmd) begin
                reg_addr_reg <= pdata_s[`CMD_ADDR_HI:`CMD_ADDR_LO];
                if (pdata_s[`CMD_WR_BIT]) begin
                    reg_wr_reg    <= 1'b1;
                    reg_wdata_reg <= pdata_s[`CMD_DATA_HI:0];
                    if (pdata_s[`CMD_ADDR_HI:`CMD_ADDR_LO] == {`ADDR_W{1'b0}})
                        sw_pair_reg <= pdata_s[`PAIR_W-1:0];
                end else begin
                    reg_out_pend_reg <= 1'b1;
                end
            end else if (reg_out_pend_reg) begin
                reg_out_pend_reg <= 1'b0;
                reg_out_reg      <= REG_RDATA_IN;
            end
        end
    end

    assign REG_WR_STROBE_OUT = reg_wr_reg;
    assign REG_ADDR_OUT      = reg_addr_reg;
    assign REG_WDATA_OUT     = reg_wdata_reg;

    // ****************************************
    // result queue and parallel readback
    // ****************************************
    reg        load_b_reg, reg_sel_reg;
    reg [`RES_W-1:0] pdout_reg;
    wire       fifo_in_ready, fifo_out_valid, fifo_pop;
    wire [`RES_W-1:0] fifo_out;
    wire       fifo_in_valid = done_pulse_reg || load_b_reg;
    wire [`RES_W-1:0] fifo_in = load_b_reg ? res_b_reg : res_a_reg;

    // bank A then bank B queued per conversion
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN)
            load_b_reg <= 1'b0;
        else if (CE_IN)
            load_b_reg <= done_pulse_reg;
    end

    result_fifo #(.WIDTH(`RES_W), .DEPTH(`FIFO_DEPTH), .AW(4)) u_fifo (
        .clk       (CLK_IN),
        .rst_n     (RST_N_IN),
        .ce        (CE_IN),
        .flush     (conv_start), // stale words dropped at each start
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out)
    );

    wire par_read = strap_done_reg && !ser_mode_reg && rd_fall && !cs_s;

    // each read fall presents the next queued word (zero when empty), or the register word after a read command
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            pdout_reg   <= `ZERO_RESULT;
            reg_sel_reg <= 1'b0;
        end else if (CE_IN) begin
            if (par_cmd && !pdata_s[`CMD_WR_BIT])
                reg_sel_reg <= 1'b1;
            if (par_read) begin
                if (reg_sel_reg) begin
                    pdout_reg   <= reg_out_reg;
                    reg_sel_reg <= 1'b0;
                end else
                    pdout_reg <= fifo_out_valid ? fifo_out : `ZERO_RESULT;
            end
        end
    end

    assign PARALLEL_DATA_LINES_OUT    = pdout_reg;
    assign PARALLEL_DATA_LINES_OE_OUT = strap_done_reg && !ser_mode_reg && !cs_s && !rd_s;

    // ****************************************
    // serial shifter
    // ****************************************
    reg [`RES_W-1:0]     sh_a_reg, sh_b_reg;
    reg [`BIT_CNT_W-1:0] bit_cnt_reg;
    reg                  sa_reg, sb_reg;
    wire ser_pop_a = ser_mode_reg && !cs_s && sclk_rise && bit_cnt_reg == {`BIT_CNT_W{1'b0}};
    wire ser_pop_b = ser_mode_reg && !cs_s && sclk_rise && bit_cnt_reg == `BIT_LAST_WORD + 1'b1
                     && !two_wire_reg;
    assign fifo_pop = (par_read && !reg_sel_reg) || ser_pop_a || (ser_pop_b && !two_wire_reg)
                      || (ser_pop_a && two_wire_reg);

    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            sh_a_reg    <= `ZERO_RESULT;
            sh_b_reg    <= `ZERO_RESULT;
            bit_cnt_reg <= {`BIT_CNT_W{1'b0}};
            sa_reg      <= 1'b0;
            sb_reg      <= 1'b0;
        end else if (CE_IN) begin
            if (cs_fall && !two_wire_reg && bit_cnt_reg != `BIT_LAST_WORD + 1'b1)
                bit_cnt_reg <= {`BIT_CNT_W{1'b0}};
            else if (cs_fall && two_wire_reg)
                bit_cnt_reg <= {`BIT_CNT_W{1'b0}};
            else if (ser_mode_reg && !cs_s && sclk_rise) begin
                if (bit_cnt_reg == {`BIT_CNT_W{1'b0}} || ser_pop_b) begin
                    // word loads, MSB goes out now
                    sa_reg   <= fifo_out_valid ? fifo_out[`RES_W-1] : 1'b0;
                    sh_a_reg <= fifo_out_valid ? {fifo_out[`RES_W-2:0], 1'b0} : `ZERO_RESULT;
                    sb_reg   <= res_b_reg[`RES_W-1];
                    sh_b_reg <= {res_b_reg[`RES_W-2:0], 1'b0};
                end else begin
                    sa_reg   <= sh_a_reg[`RES_W-1];
                    sh_a_reg <= {sh_a_reg[`RES_W-2:0], 1'b0};
                    sb_reg   <= sh_b_reg[`RES_W-1];
                    sh_b_reg <= {sh_b_reg[`RES_W-2:0], 1'b0};
                end
                if (two_wire_reg && bit_cnt_reg == `BIT_LAST_WORD)
                    bit_cnt_reg <= {`BIT_CNT_W{1'b0}};
                else if (bit_cnt_reg == `BIT_LAST_DWORD)
                    bit_cnt_reg <= {`BIT_CNT_W{1'b0}};
                else
                    bit_cnt_reg <= bit_cnt_reg + 1'b1;
            end
        end
    end

    assign SERIAL_OUT_A_OUT    = sa_reg;
    assign SERIAL_OUT_B_OUT    = sb_reg;
    assign SERIAL_OUT_A_OE_OUT = ser_mode_reg && !cs_s;
    assign SERIAL_OUT_B_OE_OUT = ser_mode_reg && !cs_s && two_wire_reg;
endmodule

// File: adc_if_defines.vh
`ifndef ADC_IF_DEFINES_VH
`define ADC_IF_DEFINES_VH
// ****************************************
// constants of the host readout interface
// ****************************************
`define RES_W          16
`define PAIR_W         3
`define ADDR_W         6
`define WDATA_W        9
`define CMD_WR_BIT     15
`define CMD_ADDR_HI    14
`define CMD_ADDR_LO    9
`define CMD_DATA_HI    8
`define PAIR_DEFAULT   3'h0
`define ZERO_RESULT    16'h0000
`define BIT_CNT_W      5
`define BIT_LAST_WORD  5'h0F
`define BIT_LAST_DWORD 5'h1F
`define CONV_TIME_NS   800
`define CLK_PERIOD_NS  40
`define CONV_CYCLES    ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CNT_W     6
`define FIFO_DEPTH     16
`endif

// File: sync2.v
`timescale 1ns/100ps
// two-flop synchroniser for a pin level
module sync2 #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         ce,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] q_reg;

    // first stage feeds only the second
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= {W{1'b0}};
            q_reg    <= {W{1'b0}};
        end else if (ce) begin
            meta_reg <= d;
            q_reg    <= meta_reg;
        end
    end
    assign q = q_reg;
endmodule

// File: result_fifo.v
`timescale 1ns/100ps
`include "adc_if_defines.vh"
// result buffer with valid/ready on both sides
module result_fifo #(
    parameter WIDTH = `RES_W,
    parameter DEPTH = `FIFO_DEPTH,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             ce,
    input  wire             flush,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    wire            push;
    wire            pop;

    // honest full and empty
    assign in_ready  = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointers and occupancy
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else if (ce) begin
            if (flush) begin
                wr_ptr_reg <= {AW{1'b0}};
                rd_ptr_reg <= {AW{1'b0}};
                count_reg  <= {(AW+1){1'b0}};
            end else begin
                if (push)
                    wr_ptr_reg <= wr_ptr_reg + 1'b1;
                if (pop)
                    rd_ptr_reg <= rd_ptr_reg + 1'b1;
                if (push && !pop)
                    count_reg <= count_reg + 1'b1;
                else if (pop && !push)
                    count_reg <= count_reg - 1'b1;
            end
        end
    end

    // storage written by index
    always @(posedge clk) begin
        if (ce && push && !flush)
            mem_reg[wr_ptr_reg] <= in_data;
    end
endmodule

// File: adc_host_readout_interface_monitor.sv
`timescale 1ns/100ps
`include "adc_if_defines.vh"
// ****************************
// readout interface checker
// ****************************
module adc_readout_checker #(
    parameter CONV_CYCLES = 20
) (
    input wire               CLK_IN,
    input wire               RST_N_IN,
    input wire               SOFTWARE_MODE_IN,
    input wire               INTERFACE_SELECT_IN,
    input wire [`PAIR_W-1:0] PAIR_SELECT_PINS_IN,
    input wire               SAMPLE_TRIGGER_IN,
    input wire               BUSY_OUT,
    input wire [`PAIR_W-1:0] CONV_PAIR_OUT,
    input wire               CS_N_IN,
    input wire               RD_N_IN,
    input wire               WR_N_IN,
    input wire               PARALLEL_DATA_LINES_OE_OUT,
    input wire               SERIAL_OUT_A_OE_OUT,
    input wire               SERIAL_OUT_B_OE_OUT,
    input wire               REG_WR_STROBE_OUT
);
    reg [7:0] busy_cnt_reg;
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);
    // length of the current busy period
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN)
            busy_cnt_reg <= 8'h00;
        else
            busy_cnt_reg <= BUSY_OUT ? busy_cnt_reg + 8'h01 : 8'h00;
    end
    a_busy_length: assert property ($fell(BUSY_OUT) |-> busy_cnt_reg == CONV_CYCLES)
        else $error("busy period has wrong length");
    a_trigger_starts_busy: assert property ($rose(SAMPLE_TRIGGER_IN) && !BUSY_OUT |-> ##[1:4] BUSY_OUT)
        else $error("trigger did not raise busy");
    a_pair_held: assert property (BUSY_OUT && $past(BUSY_OUT) |-> $stable(CONV_PAIR_OUT))
        else $error("pair changed during conversion");
    a_hw_pair_code: assert property ($rose(BUSY_OUT) && !SOFTWARE_MODE_IN |=> CONV_PAIR_OUT == PAIR_SELECT_PINS_IN)
        else $error("pair differs from pin code");
    a_par_cs_idle: assert property (CS_N_IN [*3] |-> !PARALLEL_DATA_LINES_OE_OUT)
        else $error("bus driven while deselected");
    a_par_rd_idle: assert property (RD_N_IN [*3] |-> !PARALLEL_DATA_LINES_OE_OUT)
        else $error("bus driven without read");
    a_write_sw_only: assert property (REG_WR_STROBE_OUT |-> SOFTWARE_MODE_IN && !INTERFACE_SELECT_IN)
        else $error("register write outside software parallel mode");
    a_write_on_rise: assert property (REG_WR_STROBE_OUT |-> WR_N_IN && $past(WR_N_IN, 2) ##1 !REG_WR_STROBE_OUT)
        else $error("write strobe not one pulse after rise");
    a_serial_cs_idle: assert property (CS_N_IN [*3] |-> !SERIAL_OUT_A_OE_OUT && !SERIAL_OUT_B_OE_OUT)
        else $error("serial line driven while deselected");
    c_conversion: cover property ($fell(BUSY_OUT));
    c_reg_write: cover property (REG_WR_STROBE_OUT);
    c_serial_out: cover property (SERIAL_OUT_A_OE_OUT);
endmodule

bind adc_host_readout_interface adc_readout_checker #(.CONV_CYCLES(CONV_CYCLES)) mon_u (
    .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .SOFTWARE_MODE_IN(SOFTWARE_MODE_IN),
    .INTERFACE_SELECT_IN(INTERFACE_SELECT_IN), .PAIR_SELECT_PINS_IN(PAIR_SELECT_PINS_IN),
    .SAMPLE_TRIGGER_IN(SAMPLE_TRIGGER_IN), .BUSY_OUT(BUSY_OUT), .CONV_PAIR_OUT(CONV_PAIR_OUT),
    .CS_N_IN(CS_N_IN), .RD_N_IN(RD_N_IN), .WR_N_IN(WR_N_IN),
    .PARALLEL_DATA_LINES_OE_OUT(PARALLEL_DATA_LINES_OE_OUT), .SERIAL_OUT_A_OE_OUT(SERIAL_OUT_A_OE_OUT),
    .SERIAL_OUT_B_OE_OUT(SERIAL_OUT_B_OE_OUT), .REG_WR_STROBE_OUT(REG_WR_STROBE_OUT));

// File: host_serial_model.sv
`timescale 1ns/100ps
// ***********************
// serial host controller
// ***********************
module host_serial_model (
    input  wire        clk,
    input  wire        sdo_a,
    input  wire        sdo_b,
    output reg         cs_n = 1'b1,
    output reg         sclk = 1'b0,
    output reg  [31:0] qa = 32'h0,
    output reg  [31:0] qb = 32'h0
);
    // one framed readout of n clocks, sclk parked low outside frames
    task frame(input integer n);
        integer i;
        begin
            cs_n = 1'b0;
            repeat (4) @(negedge clk);
            for (i = 0; i < n; i = i + 1) begin
                sclk = 1'b1;
                repeat (4) @(negedge clk);
                sclk = 1'b0;
                qa = {qa[30:0], sdo_a};
                qb = {qb[30:0], sdo_b};
                repeat (4) @(negedge clk);
            end
            cs_n = 1'b1;
            repeat (4) @(negedge clk);
        end
    endtask
endmodule

// File: adc_host_readout_interface_tb.sv
`timescale 1ns/100ps
`include "adc_if_defines.vh"
// ********************
// readout testbench
// ********************
module adc_host_readout_interface_tb;
    localparam CONV = 4;
    reg         clk, rst_n, sw, isel, lsel, trig, cs_n, rd_n, wr_n;
    reg  [2:0]  pins;
    reg  [15:0] res_a, res_b, dq_in, rdata, rd_word;
    reg  [31:0] seed;
    reg  [5:0]  stb_addr;
    reg  [8:0]  stb_data;
    wire        busy, oe, wstb, soa, sob, h_cs_n, sclk;
    wire [2:0]  pair;
    wire [15:0] dq;
    wire [5:0]  addr;
    wire [8:0]  wdata;
    wire [31:0] qa, qb;
    integer     fail_count, total_checks, k;
    integer     stb_count = 0;
    integer     cyc = 0;

    adc_host_readout_interface #(.CONV_CYCLES(CONV)) dut_u (
        .CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1), .SOFTWARE_MODE_IN(sw),
        .INTERFACE_SELECT_IN(isel), .LINE_COUNT_SELECT_IN(lsel), .PAIR_SELECT_PINS_IN(pins),
        .SAMPLE_TRIGGER_IN(trig), .BUSY_OUT(busy), .CONV_PAIR_OUT(pair), .BANK_A_RESULT_IN(res_a),
        .BANK_B_RESULT_IN(res_b), .CS_N_IN(isel ? h_cs_n : cs_n), .RD_N_IN(rd_n), .WR_N_IN(wr_n),
        .PARALLEL_DATA_LINES_IN(oe ? dq : dq_in), .PARALLEL_DATA_LINES_OUT(dq),
        .PARALLEL_DATA_LINES_OE_OUT(oe), .SCLK_IN(sclk), .SERIAL_OUT_A_OUT(soa), .SERIAL_OUT_A_OE_OUT(),
        .SERIAL_OUT_B_OUT(sob), .SERIAL_OUT_B_OE_OUT(), .REG_WR_STROBE_OUT(wstb), .REG_ADDR_OUT(addr),
        .REG_WDATA_OUT(wdata), .REG_RDATA_IN(rdata));
    host_serial_model host_u (.clk(clk), .sdo_a(soa), .sdo_b(sob), .cs_n(h_cs_n), .sclk(sclk), .qa(qa), .qb(qb));

    // xorshift stimulus source
    function [31:0] xs(input [31:0] v);
        reg [31:0] t;
        begin
            t = v ^ (v << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    // compares a seen value with its expectation
    task check(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", total_checks, fail_count);
            if (fail_count == 0 && total_checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // straps set, reset pulsed for 2 cycles
    task startup(input s, input i, input l, input [2:0] p);
        begin
            {sw, isel, lsel, pins} = {s, i, l, p};
            rst_n = 1'b0;
            repeat (2) @(negedge clk);
            rst_n = 1'b1;
            repeat (6) @(negedge clk);
        end
    endtask
    // conversion with fresh results, pins held until busy falls
    task convert(input [2:0] p, input [2:0] e);
        integer i;
        begin
            pins = p;
            seed = xs(seed);
            {res_a, res_b} = seed;
            @(negedge clk);
            trig = 1'b1;
            for (i = 0; i < 8 && busy !== 1'b1; i = i + 1) @(negedge clk);
            check(busy, 1);
            @(negedge clk);
            trig = 1'b0;
            check(pair, e);
            for (i = 0; i < 60 && busy !== 1'b0; i = i + 1) @(negedge clk);
            check(busy, 0);
            repeat (2) @(negedge clk);
        end
    endtask
    // parallel read cycle
    task pread(input [15:0] e);
        begin
            cs_n = 1'b0;
            rd_n = 1'b0;
            repeat (5) @(negedge clk);
            check(oe, 1);
            check(dq, e);
            rd_n = 1'b1;
            cs_n = 1'b1;
            repeat (4) @(negedge clk);
            check(oe, 0);
        end
    endtask
    // parallel write cycle, bus shows a changed pattern once released
    task pwrite(input [15:0] w);
        begin
            dq_in = w;
            cs_n = 1'b0;
            wr_n = 1'b0;
            repeat (4) @(negedge clk);
            wr_n = 1'b1;
            repeat (4) @(negedge clk);
            cs_n = 1'b1;
            dq_in = ~w;
            repeat (2) @(negedge clk);
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // records register writes issued by the design
    always @(posedge clk) begin
        if (wstb === 1'b1) begin
            stb_count <= stb_count + 1;
            stb_addr <= addr;
            stb_data <= wdata;
        end
    end
    // hang guard
    always @(negedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            print_verdict;
        end
    end

    initial begin
        {rst_n, sw, isel, lsel, trig, cs_n, rd_n, wr_n} = 8'h07;
        {pins, res_a, res_b, dq_in, rdata} = 0;
        {fail_count, total_checks} = 0;
        seed = 32'h5E1B;
        // hardware mode on the parallel bus
        startup(1'b0, 1'b0, 1'b1, 3'h5);
        check(pair, 3'h5);
        pread(16'h0000);
        sw = 1'b1;
        pwrite(16'h8006);
        check(stb_count, 0);
        sw = 1'b0;
        for (k = 0; k < 8; k = k + 1) begin
            convert(k[2:0] ^ 3'h5, k[2:0] ^ 3'h5);
            pread(res_a);
            pread(res_b);
            pread(16'h0000);
        end
        // software mode: default pair, channel register, register read
        startup(1'b1, 1'b0, 1'b1, 3'h7);
        convert(3'h7, 3'h0);
        pwrite({1'b1, 6'h00, 9'h005});
        check(stb_count, 1);
        check({stb_addr, stb_data}, {6'h00, 9'h005});
        convert(3'h7, 3'h5);
        pread(res_a);
        pread(res_b);
        seed = xs(seed);
        rdata = seed[15:0];
        pwrite({1'b0, 6'h2A, 9'h1FF});
        check(addr, 6'h2A);
        check(stb_count, 1);
        pread(rdata);
        // serial, two output lines
        startup(1'b0, 1'b1, 1'b1, 3'h2);
        convert(3'h6, 3'h6);
        host_u.frame(16);
        check(qa[15:0], res_a);
        check(qb[15:0], res_b);
        // serial, one output line, bank B after bank A
        startup(1'b0, 1'b1, 1'b0, 3'h1);
        convert(3'h1, 3'h1);
        host_u.frame(32);
        check(qa, {res_a, res_b});
        lsel = 1'b1;
        convert(3'h4, 3'h4);
        host_u.frame(16);
        check(qa[15:0], res_a);
        host_u.frame(16);
        check(qa[15:0], res_b);
        print_verdict;
    end
endmodule
